// *** hw/hler_tick.sv ***
// Purpose: one-second enable pulse divided down from ref_clk
// Assumes: SEC_PERIOD at least 2
// Notes:   restart realigns the second so a wait starts with a full second
module hler_tick
  import hler_pkg::*;
#(
  parameter int unsigned SEC_PERIOD = SEC_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic restart,
  output logic      tick
);

  logic [SEC_CNT_W-1:0] cnt_q;
  localparam logic [SEC_CNT_W-1:0] LAST = SEC_CNT_W'(SEC_PERIOD - 1);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (restart || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick = (cnt_q == LAST) && !restart;

endmodule : hler_tick

// *** hw/hler_top.sv ***
// Purpose: supervise the host link, time out, retry, recover or halt
// Assumes: requests, responses and errors are one-cycle pulses on ref_clk
// Notes:   corner presses come from pins and are synchronised here
// Functional notes
// - no host response within the time-out interval gives a time-out error
// - time-out is one to ten whole seconds, default one second
// - a communication error first retries up to the retry limit
// - retry limit ranges zero to 255, default five
// - auto recovery on and limit spent: stay running, retry without limit
// - auto recovery on never raises the error indication
// - auto recovery off and limit spent: leave run, show error, halt
// - operator acknowledge in halt restores screen and restarts attempts
// - auto recovery is one switch, off by default
// - time-out errors follow the same path as other link errors
// - two corners pressed together in error enter the system menu
module hler_top
  import hler_pkg::*;
#(
  parameter int unsigned SEC_PERIOD = SEC_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire hler_cfg_t  cfg,
  input  wire logic       cfg_load,
  input  wire hler_link_t link,
  input  wire logic       op_ack,
  input  wire logic [3:0] corner_pin,
  output logic            retry_req,
  output logic            run_mode,
  output logic            err_show,
  output logic            init_show,
  output logic            restore_screen,
  output logic            sys_menu,
  output logic            tmo_err,
  output logic [7:0]      retry_cnt
);

  hler_state_t state_q;
  hler_state_t state_d;
  logic        auto_q;
  logic [3:0]  tmo_q;
  logic [7:0]  limit_q;
  logic [3:0]  secs_q;
  logic [7:0]  cnt_q;
  logic [3:0]  cor_s1_q;
  logic [3:0]  cor_s2_q;
  logic        tick;
  logic        restart;
  logic        timed_out;
  logic        fail;
  logic        retry_q;
  logic        restore_q;
  logic        menu_q;
  logic        tmo_ev_q;

  // out-of-range intervals clamp rather than wrap
  function automatic logic [3:0] clamp_tmo(input logic [3:0] v);
    if (v < TMO_MIN) begin
      return TMO_MIN;
    end else if (v > TMO_MAX) begin
      return TMO_MAX;
    end
    return v;
  endfunction : clamp_tmo

  function automatic logic two_or_more(input logic [3:0] v);
    logic [2:0] n;
    n = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
    return n >= MENU_CORNERS;
  endfunction : two_or_more

  // settings hold factory values until loaded
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      auto_q  <= AUTO_DEFAULT;
      tmo_q   <= TMO_DEFAULT;
      limit_q <= RETRY_DEFAULT;
    end else if (cfg_load) begin
      auto_q  <= cfg.auto_recover;
      tmo_q   <= clamp_tmo(cfg.timeout_s);
      limit_q <= cfg.retry_limit;
    end
  end

  assign restart = link.req || (state_q != HLER_WAIT);

  hler_tick #(
    .SEC_PERIOD (SEC_PERIOD)
  ) u_tick (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .restart (restart),
    .tick    (tick)
  );

  // whole seconds since the request went out
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      secs_q <= '0;
    end else if (restart) begin
      secs_q <= '0;
    end else if (tick) begin
      secs_q <= secs_q + 1'b1;
    end
  end

  assign timed_out = (state_q == HLER_WAIT) && tick &&
                     (secs_q + 1'b1 >= tmo_q);
  // a time-out joins the ordinary error path
  assign fail = timed_out || (state_q == HLER_WAIT && link.comm_err);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      HLER_IDLE: begin
        if (link.req) begin
          state_d = HLER_WAIT;
        end
      end
      HLER_WAIT: begin
        if (link.resp_ok) begin
          state_d = HLER_IDLE;
        end else if (fail) begin
          state_d = HLER_ERR;
        end
      end
      HLER_ERR: begin
        if (cnt_q < limit_q || auto_q) begin
          state_d = HLER_RETRY;
        end else begin
          state_d = HLER_HALT;
        end
      end
      HLER_RETRY: begin
        state_d = HLER_WAIT;
      end
      HLER_HALT: begin
        if (op_ack) begin
          state_d = HLER_RETRY;
        end
      end
      default: state_d = HLER_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= HLER_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // saturates so endless auto retrying never wraps
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (state_q == HLER_WAIT && link.resp_ok) begin
      cnt_q <= '0;
    end else if (state_q == HLER_HALT && op_ack) begin
      cnt_q <= '0;
    end else if (state_q == HLER_ERR && state_d == HLER_RETRY &&
                 cnt_q != RETRY_SAT) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      retry_q   <= 1'b0;
      restore_q <= 1'b0;
      tmo_ev_q  <= 1'b0;
    end else begin
      retry_q   <= (state_d == HLER_RETRY);
      restore_q <= (state_q == HLER_HALT) && op_ack;
      tmo_ev_q  <= timed_out && !link.resp_ok;
    end
  end

  // corner pads are asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cor_s1_q <= CORNER_NONE;
      cor_s2_q <= CORNER_NONE;
    end else begin
      cor_s1_q <= corner_pin;
      cor_s2_q <= cor_s1_q;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      menu_q <= 1'b0;
    end else begin
      menu_q <= (state_q == HLER_HALT) && two_or_more(cor_s2_q);
    end
  end

  assign retry_req      = retry_q;
  assign restore_screen = restore_q;
  assign tmo_err        = tmo_ev_q;
  assign sys_menu       = menu_q;
  assign retry_cnt      = cnt_q;
  assign err_show       = (state_q == HLER_HALT);
  assign run_mode       = (state_q != HLER_HALT);
  assign init_show      = auto_q && (cnt_q > limit_q);

  // raw cycles since the timer last restarted, counted apart from the
  // seconds divider so the time-out check does not lean on it
  localparam int unsigned EL_W = 28;
  logic [EL_W-1:0] el_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      el_q <= '0;
    end else if (restart) begin
      el_q <= '0;
    end else begin
      el_q <= el_q + 1'b1;
    end
  end

  a_halt_needs_manual: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    state_q == HLER_HALT |-> !auto_q)
    else $error("halt entered with auto recovery on");
  a_err_to_halt: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    state_q == HLER_ERR && !auto_q && cnt_q >= limit_q |=> err_show)
    else $error("spent retries did not halt");
  a_err_retries: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    state_q == HLER_ERR && cnt_q < limit_q |=>
    retry_req ##1 state_q == HLER_WAIT)
    else $error("retry not issued");
  a_auto_keeps_run: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    auto_q && state_q == HLER_ERR |=> run_mode && state_q == HLER_RETRY)
    else $error("auto recovery left run");
  a_tmo_same_path: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    timed_out && !link.resp_ok |=> state_q == HLER_ERR && tmo_err)
    else $error("time-out not handled as error");
  a_no_early_tmo: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    timed_out |->
    el_q + EL_W'(1) >= EL_W'(tmo_q) * EL_W'(SEC_PERIOD))
    else $error("time-out before interval");
  a_ack_restores: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    state_q == HLER_HALT && op_ack |=>
    restore_screen && retry_req && retry_cnt == 8'h00)
    else $error("acknowledge did not restart");
  a_ok_clears_cnt: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    state_q == HLER_WAIT && link.resp_ok |=> retry_cnt == 8'h00)
    else $error("good response left retry count");
  a_menu_in_error: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    sys_menu |-> $past(state_q) == HLER_HALT)
    else $error("menu outside error state");
  a_tmo_cfg_range: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    tmo_q >= TMO_MIN && tmo_q <= TMO_MAX)
    else $error("time-out setting out of range");

  c_halt: cover property (@(posedge ref_clk) disable iff (!arst_n)
    state_q == HLER_HALT ##[1:20] op_ack);
  c_auto_endless: cover property (@(posedge ref_clk) disable iff (!arst_n)
    init_show && retry_req);
  c_timeout: cover property (@(posedge ref_clk) disable iff (!arst_n)
    tmo_err);
  c_menu: cover property (@(posedge ref_clk) disable iff (!arst_n)
    sys_menu);

endmodule : hler_top

// *** pkg/hler_pkg.sv ***
// Purpose: shared constants and types for the host link error recovery block
// Assumes: 10 MHz ref_clk, asynchronous active-low reset
// Notes:   settings arrive as plain inputs, no software-reachable registers
package hler_pkg;

  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned SEC_S          = 1;
  localparam int unsigned SEC_CYCLES     = SEC_S * CLK_HZ;
  localparam int unsigned SEC_CNT_W      = 24;

  localparam logic [3:0]  TMO_MIN        = 4'h1;
  localparam logic [3:0]  TMO_MAX        = 4'hA;
  localparam logic [3:0]  TMO_DEFAULT    = 4'h1;
  localparam logic [7:0]  RETRY_DEFAULT  = 8'h05;
  localparam logic        AUTO_DEFAULT   = 1'b0;
  localparam logic [3:0]  CORNER_NONE    = 4'h0;
  localparam logic [7:0]  RETRY_SAT      = 8'hFF;
  localparam logic [2:0]  MENU_CORNERS   = 3'h2;

  typedef enum logic [2:0] {
    HLER_IDLE    = 3'b000,
    HLER_WAIT    = 3'b001,
    HLER_ERR     = 3'b010,
    HLER_RETRY   = 3'b011,
    HLER_HALT    = 3'b100
  } hler_state_t;

  typedef struct packed {
    logic        auto_recover;
    logic [3:0]  timeout_s;
    logic [7:0]  retry_limit;
  } hler_cfg_t;

  typedef struct packed {
    logic        req;
    logic        resp_ok;
    logic        comm_err;
  } hler_link_t;

endpackage : hler_pkg

// *** testbench/hler_host_model.sv ***
// Purpose: host controller stand-in that answers link requests
// Assumes: mode 0 stays silent, 1 answers good, 2 answers with an error
// Notes:   the answer comes DELAY cycles after the last request seen
module hler_host_model #(
  parameter int unsigned DELAY = 3
) (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       req,
  input  wire logic [1:0] mode,
  output logic            resp_ok,
  output logic            comm_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic       busy_q;
  // a new request drops any answer still pending, like a real host would
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q    <= 4'h0;
      busy_q   <= 1'b0;
      resp_ok  <= 1'b0;
      comm_err <= 1'b0;
    end else begin
      resp_ok  <= 1'b0;
      comm_err <= 1'b0;
      if (req) begin
        busy_q <= 1'b1;
        cnt_q  <= 4'(DELAY);
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          busy_q   <= 1'b0;
          resp_ok  <= (mode == 2'h1);
          comm_err <= (mode == 2'h2);
        end
      end
    end
  end
endmodule : hler_host_model

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench for the host link error recovery block
// Assumes: one second shortened to SP cycles
// Notes:   retry_req is turned into a fresh request one cycle later
module tb_top
  import hler_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SP = 20;
  logic       ref_clk, arst_n, cfg_load, op_ack, req_go, req_q, m_ok, m_err;
  logic       retry_req, run_mode, err_show, init_show;
  logic       restore_screen, sys_menu, tmo_err;
  logic [7:0] retry_cnt;
  logic [3:0] corner_pin;
  logic [1:0] mode;
  hler_cfg_t  cfg;
  hler_link_t link;
  int         n_mismatch, samples_checked, cyc;

  assign link = '{req: req_q, resp_ok: m_ok, comm_err: m_err};
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) req_q <= 1'b0;
    else req_q <= req_go | retry_req;
  end

  hler_top #(.SEC_PERIOD(SP)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
    .cfg(cfg), .cfg_load(cfg_load), .link(link), .op_ack(op_ack),
    .corner_pin(corner_pin), .retry_req(retry_req), .run_mode(run_mode),
    .err_show(err_show), .init_show(init_show),
    .restore_screen(restore_screen), .sys_menu(sys_menu),
    .tmo_err(tmo_err), .retry_cnt(retry_cnt));
  hler_host_model host_u (.ref_clk(ref_clk), .arst_n(arst_n), .req(req_q),
    .mode(mode), .resp_ok(m_ok), .comm_err(m_err));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // a hang ends here rather than running forever
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic do_reset();
    @(posedge ref_clk) arst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
  endtask : do_reset
  task automatic pulse_req();
    @(posedge ref_clk) req_go <= 1'b1;
    @(posedge ref_clk) req_go <= 1'b0;
  endtask : pulse_req
  task automatic load(input logic a, input logic [3:0] t, input logic [7:0] l);
    @(posedge ref_clk) cfg <= '{auto_recover: a, timeout_s: t, retry_limit: l};
    cfg_load <= 1'b1;
    @(posedge ref_clk) cfg_load <= 1'b0;
  endtask : load

  // factory settings: auto off, one second, five retries, then halt
  task automatic t_default_halt();
    int n_r, n_t, first;
    n_r = 0;
    n_t = 0;
    first = 0;
    mode <= 2'h0;
    check(run_mode, 1, "run after reset");
    pulse_req();
    for (int i = 0; i < 600 && err_show !== 1'b1; i++) begin
      @(negedge ref_clk);
      n_r += int'(retry_req === 1'b1);
      n_t += int'(tmo_err === 1'b1);
      if (n_t == 1 && first == 0) first = i;
    end
    check(8'(first >= SP && first <= SP + 4), 1, "default timeout");
    check(8'(n_r), 8'd5, "retries before halt");
    check(8'(n_t), 8'd6, "timeouts before halt");
    check(run_mode, 0, "halted");
    check(err_show, 1, "error shown");
    @(posedge ref_clk) corner_pin <= 4'b1000;
    repeat (6) @(negedge ref_clk);
    check(sys_menu, 0, "one corner");
    @(posedge ref_clk) corner_pin <= 4'b1001;
    repeat (6) @(negedge ref_clk);
    check(sys_menu, 1, "two corners");
    @(posedge ref_clk) corner_pin <= 4'b0000;
    repeat (6) @(posedge ref_clk);
    op_ack <= 1'b1;
    @(posedge ref_clk) op_ack <= 1'b0;
    @(negedge ref_clk);
    check(restore_screen, 1, "screen restored");
    check(retry_req, 1, "attempts restart");
    @(negedge ref_clk);
    check(err_show, 0, "error cleared");
    check(run_mode, 1, "running again");
  endtask : t_default_halt

  task automatic t_tmo(input logic [3:0] tin, input int texp);
    int n;
    n = 0;
    load(1'b0, tin, 8'hff);
    pulse_req();
    while (n < 300 && tmo_err !== 1'b1) begin
      @(negedge ref_clk);
      n++;
    end
    check(8'(n >= texp * SP && n <= texp * SP + 4), 1, "timeout span");
  endtask : t_tmo

  task automatic t_auto();
    int n_r, shown;
    n_r = 0;
    shown = 0;
    load(1'b1, 4'h1, 8'h00);
    mode <= 2'h2;
    pulse_req();
    repeat (300) begin
      @(negedge ref_clk);
      n_r += int'(retry_req === 1'b1);
      shown += int'(err_show !== 1'b0 || run_mode !== 1'b1);
    end
    check(8'(shown != 0), 0, "no error screen");
    check(8'(n_r > 5), 1, "endless retry");
    check(init_show, 1, "initialising shown");
    mode <= 2'h1;
    for (int i = 0; i < 60 && retry_cnt !== 8'h00; i++) @(negedge ref_clk);
    check(retry_cnt, 8'h00, "count cleared");
    check(init_show, 0, "initialising gone");
  endtask : t_auto

  initial begin
    arst_n = 1'b0;
    cfg_load = 1'b0;
    op_ack = 1'b0;
    req_go = 1'b0;
    corner_pin = 4'h0;
    mode = 2'h0;
    cfg = '{auto_recover: 1'b0, timeout_s: 4'h1, retry_limit: 8'h05};
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    t_default_halt();
    do_reset();
    t_tmo(4'h2, 2);
    t_tmo(4'h0, 1);
    t_tmo(4'hA, 10);
    t_tmo(4'hF, 10);
    do_reset();
    t_auto();
    conclude();
  end
endmodule : tb_top
